// [hdl/aass_pkg.sv]
// Purpose: constants and carriers for the audio converter sleep/wake sequencer
// Assumes: pclk at 250 MHz, register word per 32-bit aligned APB address
// Notes: register indices are 8-bit page-0 indices; byte address is four times the index
package aass_pkg;
	// register indices
	localparam logic [7:0] aass_idx_sleep = 8'h02;
	localparam logic [7:0] aass_idx_insrc = 8'h41;
	localparam logic [7:0] aass_idx_pincfg = 8'h22;
	localparam logic [7:0] aass_idx_chen = 8'h73;
	localparam logic [7:0] aass_idx_sloten = 8'h74;
	localparam logic [7:0] aass_idx_pwr = 8'h75;
	localparam logic [7:0] aass_idx_state = 8'h77;
	localparam logic [7:0] aass_idx_swreset = 8'h01;
	// reset values
	localparam logic [7:0] aass_rst_sleep = 8'h00;
	localparam logic [7:0] aass_rst_chen = 8'hc0;
	localparam logic [7:0] aass_rst_sloten = 8'h00;
	localparam logic [7:0] aass_rst_pwr = 8'h00;
	localparam logic [7:0] aass_rst_insrc = 8'h00;
	localparam logic [7:0] aass_rst_pincfg = 8'h00;
	// field positions
	localparam int aass_bit_wake = 0;
	localparam int aass_bit_adc_pwr = 6;
	localparam int aass_bit_sleep_done = 7;
	localparam int aass_bit_swreset = 0;
	// timing
	localparam int aass_clk_mhz = 250;
	localparam int aass_init_us = 1000;
	localparam int aass_wake_us = 1000;
	localparam int aass_ramp_us = 6000;
	localparam int aass_init_cyc = aass_init_us * aass_clk_mhz;
	localparam int aass_wake_cyc = aass_wake_us * aass_clk_mhz;
	localparam int aass_ramp_cyc = aass_ramp_us * aass_clk_mhz;
	localparam int aass_word_bits = 32;
	localparam int aass_max_ch = 4;

	typedef enum {aass_st_init, aass_st_sleep, aass_st_waking, aass_st_active, aass_st_ramp} aass_state_t;

	// one recorded sample with its channel number, crosses to the link domain
	typedef struct packed {
		logic [1:0] ch;
		logic [31:0] data;
	} aass_sample_t;
endpackage

// [hdl/aass_regmem.sv]
// Purpose: small register memory holding the general page-0 settings
// Assumes: one write and one read per cycle
// Notes: read data registered; contents kept through sleep
`timescale 1ns/10ps
module aass_regmem #(
	parameter int aw = 8
) (
	input wire logic pclk,
	input wire logic we,
	input wire logic [aw-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [aw-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:(1<<aw)-1];

	// elaboration check: an empty or huge array makes no sense here
	if (aw < 1 || aw > 16) begin : g_bad_aw
		$error("aass_regmem: unsupported address width");
	end

	// no reset on the array so values persist and map to plain ram
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // aass_regmem

// [hdl/aass_seq.sv]
// Purpose: sleep/wake/record sequencing of a two-analog or four-pdm channel audio converter
// Assumes: APB slave on pclk; TDM link runs on the host's bit clock
// Notes: samples come from a user port; the converter itself lies outside
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
module aass_seq #(
	parameter int init_cyc = aass_pkg::aass_init_cyc,
	parameter int wake_cyc = aass_pkg::aass_wake_cyc,
	parameter int ramp_cyc = aass_pkg::aass_ramp_cyc,
	parameter int n_ch = aass_pkg::aass_max_ch
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bit_clock,
	input wire logic frame_sync,
	output logic sdout,
	output logic sdout_oe,
	input wire logic sample_valid,
	input wire aass_pkg::aass_sample_t sample_in,
	output logic sample_ready,
	output logic recording,
	output logic sleeping
);
	// elaboration check: two-bit slot counter serves one to four channels, counts must be nonzero
	if (n_ch < 1 || n_ch > aass_pkg::aass_max_ch || init_cyc < 1 || wake_cyc < 1 || ramp_cyc < 1) begin : g_bad_param
		$error("aass_seq: unsupported parameter");
	end

	localparam int cw = 32;

	// index decode used by write and read paths
	function automatic logic is_idx(input logic [11:0] a, input logic [7:0] idx);
		return a[11:10] == 2'b00 && a[9:2] == idx && a[1:0] == 2'b00;
	endfunction

	aass_pkg::aass_state_t state, next_state;
	logic [cw-1:0] timer;
	logic [7:0] sleep_reg, chen, sloten, pwr;
	logic sleep_done;
	logic [7:0] mem_rdata;
	logic rd_pend, rd_mem;
	logic [31:0] rd_hold;

	wire logic setup = psel && !penable;
	wire logic wr_acc = psel && penable && pwrite && pready;
	wire logic in_page = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00;
	wire logic wr_sleep = wr_acc && is_idx(paddr, aass_pkg::aass_idx_sleep);
	wire logic wr_chen = wr_acc && is_idx(paddr, aass_pkg::aass_idx_chen);
	wire logic wr_slot = wr_acc && is_idx(paddr, aass_pkg::aass_idx_sloten);
	wire logic wr_pwr = wr_acc && is_idx(paddr, aass_pkg::aass_idx_pwr);
	wire logic wr_rst = wr_acc && is_idx(paddr, aass_pkg::aass_idx_swreset) && pwdata[aass_pkg::aass_bit_swreset];
	wire logic wr_state = wr_acc && is_idx(paddr, aass_pkg::aass_idx_state);
	// general memory takes every other page-0 index
	wire logic wr_mem = wr_acc && in_page && !wr_sleep && !wr_chen && !wr_slot && !wr_pwr && !wr_rst && !wr_state
		&& !is_idx(paddr, aass_pkg::aass_idx_swreset);

	aass_regmem #(.aw(8)) u_mem (
		.pclk(pclk),
		.we(wr_mem),
		.waddr(paddr[9:2]),
		.wdata(pwdata[7:0]),
		.raddr(paddr[9:2]),
		.rdata(mem_rdata)
	);

	// state machine: init, sleep, wake wait, active, ramp-down
	always_comb begin
		next_state = state;
		case (state)
			aass_pkg::aass_st_init: if (timer == cw'(init_cyc - 1)) next_state = aass_pkg::aass_st_sleep;
			aass_pkg::aass_st_sleep: if (wr_sleep && pwdata[aass_pkg::aass_bit_wake]) next_state = aass_pkg::aass_st_waking;
			aass_pkg::aass_st_waking: if (timer == cw'(wake_cyc - 1)) next_state = aass_pkg::aass_st_active;
			aass_pkg::aass_st_active: if (wr_sleep && !pwdata[aass_pkg::aass_bit_wake]) next_state = aass_pkg::aass_st_ramp;
			aass_pkg::aass_st_ramp: if (timer == cw'(ramp_cyc - 1)) next_state = aass_pkg::aass_st_sleep;
			default: next_state = aass_pkg::aass_st_init;
		endcase
		if (wr_rst) begin
			next_state = aass_pkg::aass_st_init;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= aass_pkg::aass_st_init;
		end else begin
			state <= next_state;
		end
	end

	// timer restarts on every state change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer <= '0;
		end else if (next_state != state) begin
			timer <= '0;
		end else begin
			timer <= timer + cw'(1);
		end
	end

	// shutdown status sets when the ramp or init ends in sleep, clears on wake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_done <= 1'b0;
		end else if (state == aass_pkg::aass_st_ramp && next_state == aass_pkg::aass_st_sleep) begin
			sleep_done <= 1'b1;
		end else if (state == aass_pkg::aass_st_init && next_state == aass_pkg::aass_st_sleep) begin
			sleep_done <= 1'b1;
		end else if (next_state == aass_pkg::aass_st_waking) begin
			sleep_done <= 1'b0;
		end
	end

	// control registers; not touched by sleep so wake resumes as before
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_reg <= aass_pkg::aass_rst_sleep;
			chen <= aass_pkg::aass_rst_chen;
			sloten <= aass_pkg::aass_rst_sloten;
			pwr <= aass_pkg::aass_rst_pwr;
		end else if (wr_rst) begin
			sleep_reg <= aass_pkg::aass_rst_sleep;
			chen <= aass_pkg::aass_rst_chen;
			sloten <= aass_pkg::aass_rst_sloten;
			pwr <= aass_pkg::aass_rst_pwr;
		end else begin
			if (wr_sleep) sleep_reg <= pwdata[7:0];
			if (wr_chen) chen <= pwdata[7:0];
			if (wr_slot) sloten <= pwdata[7:0];
			if (wr_pwr) pwr <= pwdata[7:0];
		end
	end

	// apb: every access, read or write, waits one extra cycle so memory read data is ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
			rd_pend <= 1'b0;
			rd_mem <= 1'b0;
			rd_hold <= '0;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			if (setup) begin
				rd_pend <= 1'b1;
				rd_mem <= 1'b0;
				rd_hold <= '0;
				if (is_idx(paddr, aass_pkg::aass_idx_sleep)) rd_hold <= {24'h0, sleep_reg};
				else if (is_idx(paddr, aass_pkg::aass_idx_chen)) rd_hold <= {24'h0, chen};
				else if (is_idx(paddr, aass_pkg::aass_idx_sloten)) rd_hold <= {24'h0, sloten};
				else if (is_idx(paddr, aass_pkg::aass_idx_pwr)) rd_hold <= {24'h0, pwr};
				else if (is_idx(paddr, aass_pkg::aass_idx_state)) rd_hold <= {24'h0, sleep_done, 7'h0};
				else if (is_idx(paddr, aass_pkg::aass_idx_swreset)) rd_hold <= '0;
				else rd_mem <= in_page;
			end else if (rd_pend && psel && penable) begin
				rd_pend <= 1'b0;
				pready <= 1'b1;
				pslverr <= !in_page;
				prdata <= rd_mem ? {24'h0, mem_rdata} : rd_hold;
			end
		end
	end

	// recording is live when active, a channel and slot enabled and converter powered
	wire logic rec_en = state == aass_pkg::aass_st_active && |(chen & sloten) && pwr[aass_pkg::aass_bit_adc_pwr];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recording <= 1'b0;
			sleeping <= 1'b0;
		end else begin
			recording <= rec_en;
			sleeping <= state == aass_pkg::aass_st_sleep;
		end
	end

	// sample hand-off: pclk holds a word and toggles, link acknowledges by toggle
	aass_pkg::aass_sample_t hold;
	logic [3:0] hold_en;
	logic req_tgl, ack_s1, ack_s2, ack_s3, busy;
	logic ack_tgl;
	logic req_l1, req_l2, req_l3;

	// ready is a flop: it drops on the take edge so one word is in flight at a time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold <= '0;
			hold_en <= 4'h0;
			req_tgl <= 1'b0;
			busy <= 1'b0;
			sample_ready <= 1'b0;
			{ack_s1, ack_s2, ack_s3} <= 3'b000;
		end else begin
			{ack_s1, ack_s2, ack_s3} <= {ack_tgl, ack_s1, ack_s2};
			sample_ready <= rec_en && !busy && !(sample_valid && sample_ready);
			if (sample_valid && sample_ready) begin
				hold <= sample_in;
				hold_en <= sloten[7:4]; // slot enables ride along with the word
				req_tgl <= !req_tgl;
				busy <= 1'b1;
			end else if (busy && ack_s2 == ack_s3 && ack_s3 == req_tgl) begin
				busy <= 1'b0;
			end
		end
	end

	// link domain: frame sync marks slot 0, shift msb first on the rising edge
	logic [3:0] sloten_l;
	logic [31:0] slot_word [0:aass_pkg::aass_max_ch-1];
	logic [31:0] shreg;
	logic fs_d, rec_l1, rec_l2, rec_l3, tail;
	logic [1:0] slot;
	logic [4:0] bitn;

	always_ff @(posedge bit_clock or negedge presetn) begin
		if (!presetn) begin
			{req_l1, req_l2, req_l3} <= 3'b000;
			{rec_l1, rec_l2, rec_l3} <= 3'b000;
			ack_tgl <= 1'b0;
			fs_d <= 1'b0;
			slot <= 2'd0;
			bitn <= 5'd0;
			shreg <= '0;
			sdout <= 1'b0;
			sdout_oe <= 1'b0;
			tail <= 1'b1; // quiet until the first frame sync
			sloten_l <= 4'h0;
			for (int i = 0; i < aass_pkg::aass_max_ch; i++) slot_word[i] <= '0;
		end else begin
			{req_l1, req_l2, req_l3} <= {req_tgl, req_l1, req_l2};
			{rec_l1, rec_l2, rec_l3} <= {rec_en, rec_l1, rec_l2};
			fs_d <= frame_sync;
			// word stays stable in pclk domain until ack is seen
			if (req_l2 == req_l3 && req_l3 != ack_tgl) begin
				slot_word[hold.ch] <= hold.data;
				sloten_l <= hold_en;
				ack_tgl <= req_l3;
			end
			if (frame_sync && !fs_d) begin
				slot <= 2'd0;
				bitn <= 5'd1;
				tail <= 1'b0;
				shreg <= {slot_word[0][30:0], 1'b0};
				sdout <= slot_word[0][31] && rec_l3 && sloten_l[0];
				sdout_oe <= rec_l3 && sloten_l[0];
			end else if (tail) begin
				// past the last slot the line stays released until the next frame
				sdout <= 1'b0;
				sdout_oe <= 1'b0;
			end else begin
				bitn <= bitn + 5'd1;
				if (bitn == 5'd31) begin
					// bit 0 goes out now; next slot's msb follows on the next edge
					slot <= slot + 2'd1;
					shreg <= slot_word[slot + 2'd1];
					tail <= int'(slot) + 1 >= n_ch;
				end else begin
					shreg <= {shreg[30:0], 1'b0};
				end
				sdout <= shreg[31] && rec_l3 && sloten_l[slot];
				sdout_oe <= rec_l3 && sloten_l[slot];
			end
		end
	end

	// assertions
	property p_init_to_sleep;
		@(posedge pclk) disable iff (!presetn)
		(state == aass_pkg::aass_st_init && timer == cw'(init_cyc - 1) && !wr_rst) |=> state == aass_pkg::aass_st_sleep;
	endproperty
	a_init_to_sleep: assert property (p_init_to_sleep) else $error("init did not end in sleep");

	property p_sleep_stays;
		@(posedge pclk) disable iff (!presetn)
		(state == aass_pkg::aass_st_sleep && !wr_sleep && !wr_rst) |=> state == aass_pkg::aass_st_sleep;
	endproperty
	a_sleep_stays: assert property (p_sleep_stays) else $error("left sleep without wake write");

	sequence s_sleep_req;
		state == aass_pkg::aass_st_active && wr_sleep && !pwdata[aass_pkg::aass_bit_wake] && !wr_rst;
	endsequence
	property p_done_after_ramp;
		@(posedge pclk) disable iff (!presetn)
		s_sleep_req |=> !sleep_done throughout (state == aass_pkg::aass_st_ramp)[*2];
	endproperty
	a_done_after_ramp: assert property (p_done_after_ramp) else $error("shutdown flag early");

	property p_done_set;
		@(posedge pclk) disable iff (!presetn)
		(state == aass_pkg::aass_st_sleep) |-> sleep_done;
	endproperty
	a_done_set: assert property (p_done_set) else $error("sleep without shutdown flag");

	property p_regs_kept;
		@(posedge pclk) disable iff (!presetn)
		(state == aass_pkg::aass_st_sleep && !wr_chen && !wr_rst) |=> chen == $past(chen);
	endproperty
	a_regs_kept: assert property (p_regs_kept) else $error("enable lost in sleep");

	property p_rec_needs_active;
		@(posedge pclk) disable iff (!presetn)
		recording |-> $past(state) == aass_pkg::aass_st_active && $past(pwr[aass_pkg::aass_bit_adc_pwr]);
	endproperty
	a_rec_needs_active: assert property (p_rec_needs_active) else $error("recording while not active");

	property p_wake_wait;
		@(posedge pclk) disable iff (!presetn)
		(state == aass_pkg::aass_st_sleep && wr_sleep && pwdata[aass_pkg::aass_bit_wake] && !wr_rst)
			|=> state == aass_pkg::aass_st_waking ##1 state == aass_pkg::aass_st_waking;
	endproperty
	a_wake_wait: assert property (p_wake_wait) else $error("wake wait skipped");

	property p_apb_answer;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> ##[0:2] pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb access never answered");

	property p_take_blocks;
		@(posedge pclk) disable iff (!presetn)
		(sample_valid && sample_ready) |=> !sample_ready && busy;
	endproperty
	a_take_blocks: assert property (p_take_blocks) else $error("sample taken while one still in flight");

	property p_rec_drops;
		@(posedge pclk) disable iff (!presetn)
		s_sleep_req |=> ##1 !recording;
	endproperty
	a_rec_drops: assert property (p_rec_drops) else $error("recording outlived sleep request");

	property p_tail_quiet;
		@(posedge bit_clock) disable iff (!presetn)
		(tail && !(frame_sync && !fs_d)) |=> !sdout_oe;
	endproperty
	a_tail_quiet: assert property (p_tail_quiet) else $error("output driven past the last slot");
endmodule // aass_seq

// [sim/aass_host_link.sv]
// Purpose: host side of the tdm link, makes frame sync and bit clock, captures slots
// Assumes: device launches slot 0 bit 31 on the rising edge that sees frame sync high
// Notes: clock stands still while run is low; run is only looked at between frames
`timescale 1ns/10ps
module aass_host_link #(
	parameter int ratio = 256
) (
	input wire logic run,
	output logic bit_clock,
	output logic frame_sync,
	input wire logic sdout,
	input wire logic sdout_oe,
	output logic [127:0] frame_bits,
	output logic [3:0] slot_oe,
	output int frames
);
	logic [127:0] shift;
	logic [3:0] oe_acc;
	// 80 ns bit clock, odd start offset so phase is unrelated to pclk
	initial begin
		bit_clock = 1'b0;
		frame_sync = 1'b0;
		frame_bits = '0;
		slot_oe = 4'h0;
		frames = 0;
		#7;
		forever begin
			if (!run) begin
				#40;
			end else begin
				// full frames only, never cut a frame short when stopping
				for (int e = 0; e < ratio; e++) begin
					frame_sync = (e == 0);
					#40 bit_clock = 1'b1;
					#40 bit_clock = 1'b0;
					// sample on falling edge, half a bit after launch
					if (e < 128) begin
						shift[127 - e] = sdout;
					end
					if (e < 128 && e % 32 == 16) begin
						oe_acc[e / 32] = sdout_oe;
					end
				end
				frame_bits = shift;
				slot_oe = oe_acc;
				frames++;
			end
		end
	end
endmodule // aass_host_link

// [sim/aass_seq_test.sv]
// Purpose: self-checking bench for the sleep/wake/record sequencer
// Assumes: apb answer within a few cycles; shortened init, wake and ramp counts
// Notes: host link model runs only between wake and confirmed shutdown
`timescale 1ns/10ps
module aass_seq_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, bit_clock, frame_sync, sdout, sdout_oe, sample_ready, recording, sleeping;
	logic sample_valid = 1'b0;
	aass_pkg::aass_sample_t sample_in = '0;
	logic run = 1'b0;
	logic [127:0] frame_bits;
	logic [3:0] slot_oe;
	int frames;
	int bad_count = 0;
	int checks = 0;
	logic [31:0] q;
	logic err;

	always #2 pclk = ~pclk;

	aass_seq #(.init_cyc(20), .wake_cyc(20), .ramp_cyc(40), .n_ch(4)) i_aass_seq (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bit_clock(bit_clock), .frame_sync(frame_sync), .sdout(sdout),
		.sdout_oe(sdout_oe), .sample_valid(sample_valid), .sample_in(sample_in), .sample_ready(sample_ready),
		.recording(recording), .sleeping(sleeping));
	aass_host_link #(.ratio(256)) i_aass_host_link (.run(run), .bit_clock(bit_clock), .frame_sync(frame_sync),
		.sdout(sdout), .sdout_oe(sdout_oe), .frame_bits(frame_bits), .slot_oe(slot_oe), .frames(frames));

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
		checks++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
			bad_count++;
		end
	endtask

	// one apb transfer; idle edge first so release and next setup never share a step
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			final_report();
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, {2'b00, idx, 2'b00}, {24'h0, d});
	endtask

	task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, {2'b00, idx, 2'b00}, 32'h0);
		chk(nm, {96'h0, q}, {120'h0, exp});
	endtask

	// bounded wait on the sleeping level
	task automatic wait_sleep(input logic v, input int lim);
		int n;
		n = 0;
		while (sleeping !== v && n < lim) begin
			@(posedge pclk);
			n++;
		end
		if (n >= lim) begin
			bad_count++;
			final_report();
		end
	endtask

	// offer one sample per channel, then wait for two frame ends
	task automatic feed_and_check(input string nm);
		int n, f0;
		for (int c = 0; c < 4; c++) begin
			n = 0;
			sample_in.ch <= c[1:0];
			sample_in.data <= 32'h5a5a_0000 + 32'(c);
			sample_valid <= 1'b1;
			do begin
				@(posedge pclk);
				n++;
			end while (sample_ready !== 1'b1 && n < 20000);
			sample_valid <= 1'b0;
			@(posedge pclk);
			if (n >= 20000) begin
				bad_count++;
				final_report();
			end
		end
		f0 = frames;
		n = 0;
		while (frames < f0 + 2 && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20000) begin
			bad_count++;
			final_report();
		end
		chk(nm, frame_bits, {32'h5a5a_0000, 32'h5a5a_0001, 32'h5a5a_0002, 32'h5a5a_0003});
		chk("slot_oe", {124'h0, slot_oe}, {124'h0, 4'hf});
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		@(posedge pclk);
		chk("sleeping_init", {127'h0, sleeping}, 128'h0);
		wait_sleep(1'b1, 40);
		wr(aass_pkg::aass_idx_swreset, 8'h01);
		wait_sleep(1'b0, 4);
		wait_sleep(1'b1, 40);
		rd("state_init", aass_pkg::aass_idx_state, 8'h80);
		rd("chen_rst", aass_pkg::aass_idx_chen, aass_pkg::aass_rst_chen);
		rd("sloten_rst", aass_pkg::aass_idx_sloten, aass_pkg::aass_rst_sloten);
		rd("pwr_rst", aass_pkg::aass_idx_pwr, aass_pkg::aass_rst_pwr);
		apb(1'b0, 12'h400, 32'h0);
		chk("unmapped_err", {127'h0, err}, 128'h1);
		$display("test reset done");
		// wake, then pdm pin setup ahead of enables
		wr(aass_pkg::aass_idx_sleep, 8'h01);
		rd("state_wake", aass_pkg::aass_idx_state, 8'h00);
		wait_sleep(1'b0, 40);
		repeat (24) @(posedge pclk);
		run <= 1'b1;
		wr(aass_pkg::aass_idx_insrc, 8'h40);
		wr(aass_pkg::aass_idx_pincfg, 8'h41);
		wr(aass_pkg::aass_idx_chen, 8'hf0);
		wr(aass_pkg::aass_idx_sloten, 8'hf0);
		chk("rec_unpowered", {127'h0, recording}, 128'h0);
		wr(aass_pkg::aass_idx_pwr, 8'he0);
		@(posedge pclk);
		@(posedge pclk);
		chk("rec_on", {127'h0, recording}, 128'h1);
		feed_and_check("frame_first");
		$display("test record done");
		// sleep entry: status clear during ramp, set once done, then clocks stop
		wr(aass_pkg::aass_idx_sleep, 8'h00);
		rd("state_ramp", aass_pkg::aass_idx_state, 8'h00);
		repeat (60) @(posedge pclk);
		rd("state_done", aass_pkg::aass_idx_state, 8'h80);
		chk("sleeping_done", {127'h0, sleeping}, 128'h1);
		chk("rec_off", {127'h0, recording}, 128'h0);
		run <= 1'b0;
		rd("insrc_kept", aass_pkg::aass_idx_insrc, 8'h40);
		rd("chen_kept", aass_pkg::aass_idx_chen, 8'hf0);
		rd("pwr_kept", aass_pkg::aass_idx_pwr, 8'he0);
		$display("test sleep done");
		// mode transition: wake only, recording resumes without reprogramming
		wr(aass_pkg::aass_idx_sleep, 8'h01);
		wait_sleep(1'b0, 40);
		repeat (24) @(posedge pclk);
		run <= 1'b1;
		@(posedge pclk);
		chk("rec_resume", {127'h0, recording}, 128'h1);
		feed_and_check("frame_resume");
		$display("test resume done");
		final_report();
	end
endmodule // aass_seq_test
